/* pkg/light_timing_pkg.sv */
// shared constants and carrier types for the integration timing block
package light_timing_pkg;
    // command register (address zero) field positions
    localparam int unsigned CMD_WIDTH_LSB  = 0;
    localparam int unsigned CMD_DIODE_LSB  = 2;
    localparam int unsigned CMD_TIMING_BIT = 5;
    // control register (address one) field position
    localparam int unsigned CTL_RANGE_LSB  = 2;
    // timer data byte addresses
    localparam logic [7:0] TIMER_LSB_ADDR  = 8'h06;
    localparam logic [7:0] TIMER_MSB_ADDR  = 8'h07;
    // width codes and their cycle-count exponents
    localparam logic [1:0] WIDTH_16        = 2'h0;
    localparam logic [1:0] WIDTH_12        = 2'h1;
    localparam logic [1:0] WIDTH_8         = 2'h2;
    localparam logic [1:0] WIDTH_4         = 2'h3;
    // diode select codes
    localparam logic [1:0] DIODE_ONE       = 2'h0;
    localparam logic [1:0] DIODE_TWO       = 2'h1;
    localparam logic [1:0] DIODE_DIFF      = 2'h2;
    localparam logic [1:0] DIODE_NOP       = 2'h3;
    // counter width and reset values
    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] CNT_RESET      = 16'h0000;
    // core clock and default oscillator divider (full rate)
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned OSC_FULL_KHZ   = 655;
    localparam int unsigned OSC_DIV_FULL   = (CLK_MHZ * 1000) / OSC_FULL_KHZ;

    typedef struct packed {
        logic       ext_timing;
        logic [1:0] diode_sel;
        logic [1:0] width;
    } cmd_s;

    typedef struct packed {
        logic        valid;
        logic        diode_two;
        logic        difference;
        logic [15:0] cycles;
    } period_s;
endpackage : light_timing_pkg

/* rtl/light_adc_integration_timing.sv */
// integration timing control for an integrating light-to-digital converter
// How it works
// - internal mode ends integration after exactly 2^n oscillator ticks
// - exponent n comes from command bits 1:0
// - command bit 5 picks internal or host-synced timing
// - ranges one and two run oscillator at half rate, three and four full
// - rate choice ignores timing mode
// - single-diode external: sync starts, next sync ends integration
// - external mode: each sync after the first ends integration and, unless diode code is 11, starts a new one
// - difference mode syncs alternate diode one then diode two
// - external mode counts real oscillator ticks, sixteen bits
// - last period tick count is offered to the host
// - result is an unsigned count in the data output
// - gain range is one of four, changeable at run time
// - width 00,01,10,11 give 65536, 4096, 256, 16 ticks
// - gain range sits in control bits 3:2
// - counter low byte at address six, high at seven
// - diode code 00 one, 01 two, 10 difference, 11 idle
`timescale 1ns/1ns
`default_nettype none
module light_adc_integration_timing #(
    parameter int unsigned OSC_DIV = light_timing_pkg::OSC_DIV_FULL
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register contents written by the serial host
    input  wire logic [7:0]  command_reg,
    input  wire logic [7:0]  control_reg,
    // sync command pulse from the serial front end
    input  wire logic        sync_pulse,
    // byte read port for timer data
    input  wire logic [7:0]  read_addr,
    output logic      [7:0]  read_data,
    // photocurrent pulses from the analog modulator (asynchronous)
    input  wire logic        quanta_pin,
    // diode mux and integrator control
    output logic             diode_two_sel,
    output logic             integrating,
    output logic             oscillator_half,
    // conversion results
    output logic      [15:0] sensor_data,
    output logic      [15:0] timer_data,
    output logic             period_done
);
    typedef enum logic [1:0] {IDLE, WAIT_FIRST, RUN} seq_e;

    light_timing_pkg::cmd_s    cmd;
    light_timing_pkg::period_s period;
    logic [1:0]  range_code;
    logic        half_d;
    logic        tick;
    logic        quanta_rise;
    seq_e        seq_q;
    seq_e        seq_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic        diode_q;
    logic        diode_d;
    logic [15:0] d1_q;
    logic [15:0] d1_d;
    logic [15:0] sensor_d;
    logic [15:0] timer_d;
    logic        done_d;
    logic [7:0]  rdata_d;
    logic [15:0] target;
    logic        end_now;
    logic [15:0] cnt_inc;
    logic [15:0] acc_inc;
    logic        integ_d;
    logic        diode_out_d;

    // field decode of the two registers
    // width field decode
    assign cmd.width      = command_reg[light_timing_pkg::CMD_WIDTH_LSB +: 2];
    assign cmd.diode_sel  = command_reg[light_timing_pkg::CMD_DIODE_LSB +: 2];
    assign cmd.ext_timing = command_reg[light_timing_pkg::CMD_TIMING_BIT];
    assign range_code     = control_reg[light_timing_pkg::CTL_RANGE_LSB +: 2];
    assign half_d         = ~range_code[1];

    osc_tick #(
        .DIV       (OSC_DIV)
    ) u_osc (
        .clk       (clk),
        .rst_n     (rst_n),
        .half_rate (half_d),
        .tick      (tick)
    );

    // modulator pulses come from the analog side, so resynchronise
    // a pulse or gap shorter than two clocks can be lost here
    pin_sync u_quanta (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (quanta_pin),
        .level (),
        .rise  (quanta_rise)
    );

    // terminal count, held as count-minus-one
    // width code to cycles
    always_comb begin
        case (cmd.width)
            light_timing_pkg::WIDTH_16: target = 16'hFFFF;
            light_timing_pkg::WIDTH_12: target = 16'h0FFF;
            light_timing_pkg::WIDTH_8:  target = 16'h00FF;
            light_timing_pkg::WIDTH_4:  target = 16'h000F;
            default:                    target = 16'hFFFF;
        endcase
    end

    // end of period: sync in external mode, terminal tick in internal;
    // a sync in internal mode is deliberately ignored
    always_comb begin
        if (cmd.ext_timing) begin
            end_now = (seq_q == RUN) && sync_pulse;
        end else begin
            end_now = (seq_q == RUN) && tick && (cnt_q == target);
        end
    end

    // raw increments; the sequencer below overrides them with clears
    always_comb begin
        cnt_inc = cnt_q;
        acc_inc = acc_q;
        // photocurrent quanta accumulate only while integrating
        if (seq_q == RUN && quanta_rise) begin
            acc_inc = acc_q + 16'h0001;
        end
        // count real oscillator ticks; past 65,535 the count wraps
        if (seq_q == RUN && tick) begin
            cnt_inc = cnt_q + 16'h0001;
        end
    end

    // sequencer and result capture
    always_comb begin
        seq_d    = seq_q;
        cnt_d    = cnt_inc;
        acc_d    = acc_inc;
        diode_d  = diode_q;
        d1_d     = d1_q;
        sensor_d = sensor_data;
        timer_d  = timer_data;
        done_d   = 1'b0;
        period   = '0;
        case (seq_q)
            IDLE: begin
                // internal timing starts at once, host timing waits for a sync
                if (cmd.diode_sel != light_timing_pkg::DIODE_NOP) begin
                    seq_d   = cmd.ext_timing ? WAIT_FIRST : RUN;
                    diode_d = (cmd.diode_sel == light_timing_pkg::DIODE_TWO);
                    cnt_d   = light_timing_pkg::CNT_RESET;
                    acc_d   = light_timing_pkg::CNT_RESET;
                end
            end
            WAIT_FIRST: begin
                // ticks before the first sync belong to no period
                // first sync starts integration
                if (sync_pulse) begin
                    seq_d = RUN;
                    cnt_d = light_timing_pkg::CNT_RESET;
                    acc_d = light_timing_pkg::CNT_RESET;
                end
            end
            RUN: begin
                if (end_now) begin
                    period.valid      = 1'b1;
                    period.diode_two  = diode_q;
                    period.difference = (cmd.diode_sel == light_timing_pkg::DIODE_DIFF);
                    // internal mode counter wraps to zero at 2^16, so report target+1
                    period.cycles     = cmd.ext_timing ? cnt_d : target + 16'h0001;
                    cnt_d = light_timing_pkg::CNT_RESET;
                    acc_d = light_timing_pkg::CNT_RESET;
                    if (period.difference) begin
                        diode_d = ~diode_q;
                        if (!diode_q) begin
                            d1_d = acc_d_capture(acc_q, quanta_rise);
                        end else begin
                            sensor_d = diff_floor(d1_q, acc_q, quanta_rise);
                            done_d   = 1'b1;
                            timer_d  = period.cycles;
                        end
                    end else begin
                        sensor_d = acc_d_capture(acc_q, quanta_rise);
                        timer_d  = period.cycles;
                        done_d   = 1'b1;
                        diode_d  = (cmd.diode_sel == light_timing_pkg::DIODE_TWO);
                    end
                    if (cmd.diode_sel == light_timing_pkg::DIODE_NOP) begin
                        seq_d = IDLE;
                    end
                end
            end
            default: seq_d = IDLE;
        endcase
    end

    // count including a quantum that lands on the closing cycle
    function automatic logic [15:0] acc_d_capture(
        input logic [15:0] a,
        input logic        q
    );
        acc_d_capture = q ? a + 16'h0001 : a;
    endfunction : acc_d_capture

    // diode one minus diode two, clamped so the output stays unsigned
    function automatic logic [15:0] diff_floor(
        input logic [15:0] one,
        input logic [15:0] a,
        input logic        q
    );
        logic [15:0] two;
        two        = q ? a + 16'h0001 : a;
        diff_floor = (one > two) ? one - two : 16'h0000;
    endfunction : diff_floor

    always_comb begin
        case (read_addr)
            light_timing_pkg::TIMER_LSB_ADDR: rdata_d = timer_data[7:0];
            light_timing_pkg::TIMER_MSB_ADDR: rdata_d = timer_data[15:8];
            default:                          rdata_d = 8'h00;
        endcase
    end

    // read port register, one cycle behind the address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_data <= 8'h00;
        end else begin
            read_data <= rdata_d;
        end
    end

    // status next values; integrating follows the next state so the
    // integrator switches on the same edge as the sequencer
    always_comb begin
        integ_d     = (seq_d == RUN);
        diode_out_d = diode_d;
    end

    // sequencer state and counters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_q   <= IDLE;
            cnt_q   <= light_timing_pkg::CNT_RESET;
            acc_q   <= light_timing_pkg::CNT_RESET;
            diode_q <= 1'b0;
            d1_q    <= 16'h0000;
        end else begin
            seq_q   <= seq_d;
            cnt_q   <= cnt_d;
            acc_q   <= acc_d;
            diode_q <= diode_d;
            d1_q    <= d1_d;
        end
    end

    // results stand until the next period end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sensor_data <= 16'h0000;
            timer_data  <= 16'h0000;
            period_done <= 1'b0;
        end else begin
            sensor_data <= sensor_d;
            timer_data  <= timer_d;
            period_done <= done_d;
        end
    end

    // mux, integrator and rate pins; reset leaves the slow rate, the safer
    // choice while the range field is still unknown
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diode_two_sel   <= 1'b0;
            integrating     <= 1'b0;
            oscillator_half <= 1'b1;
        end else begin
            diode_two_sel   <= diode_out_d;
            integrating     <= integ_d;
            oscillator_half <= half_d;
        end
    end
endmodule : light_adc_integration_timing
`default_nettype wire

/* rtl/osc_tick.sv */
// divider producing oscillator tick enables at full or half rate
`timescale 1ns/1ns
`default_nettype none
module osc_tick #(
    parameter int unsigned DIV = light_timing_pkg::OSC_DIV_FULL
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // rate select
    input  wire logic half_rate,
    // tick out
    output logic      tick
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        phase_q;
    logic        phase_d;
    logic        tick_d;
    localparam logic [15:0] LAST = 16'(DIV - 1);

    // half rate swallows every second full-rate tick
    always_comb begin
        cnt_d   = cnt_q + 16'h0001;
        phase_d = phase_q;
        tick_d  = 1'b0;
        if (cnt_q >= LAST) begin
            cnt_d   = 16'h0000;
            phase_d = ~phase_q;
            tick_d  = ~half_rate | phase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q   <= 16'h0000;
            phase_q <= 1'b0;
            tick    <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            tick    <= tick_d;
        end
    end
endmodule : osc_tick
`default_nettype wire

/* rtl/pin_sync.sv */
// three-stage synchroniser with change qualified by stages two and three
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // asynchronous input
    input  wire logic pin,
    // qualified level and rising edge
    output logic      level,
    output logic      rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;
    logic rise_d;

    // stage one feeds stage two only
    always_comb begin
        level_d = level;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
        rise_d = level_d & ~level;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= level_d;
            rise  <= rise_d;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* tb/light_adc_integration_timing_tb.sv */
// self-checking bench for the integration timing block
`timescale 1ns/1ns
`default_nettype none
module light_adc_integration_timing_tb;
    localparam int DIV = 2;
    // sync spacing far below counter wrap
    localparam int GAP = 200;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  command_reg = 8'h00;
    logic [7:0]  control_reg = 8'h00;
    logic [7:0]  read_addr = 8'h00;
    logic        quanta_pin = 1'b0;
    logic        fire = 1'b0;
    logic        sync_pulse, diode_two_sel, integrating, oscillator_half, period_done;
    logic [7:0]  read_data;
    logic [15:0] sensor_data, timer_data;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc_cnt = 0;
    logic [31:0] seed = 32'h58E0;
    logic [1:0]  wt [4] = '{2'h3, 2'h3, 2'h2, 2'h1};
    logic [1:0]  rg [4] = '{2'h0, 2'h3, 2'h1, 2'h2};

    // core clock and cycle count
    always #5 clk = ~clk;
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    light_adc_integration_timing #(.OSC_DIV(DIV)) light_adc_integration_timing_inst (
        .clk(clk), .rst_n(rst_n), .command_reg(command_reg), .control_reg(control_reg),
        .sync_pulse(sync_pulse), .read_addr(read_addr), .read_data(read_data),
        .quanta_pin(quanta_pin), .diode_two_sel(diode_two_sel), .integrating(integrating),
        .oscillator_half(oscillator_half), .sensor_data(sensor_data),
        .timer_data(timer_data), .period_done(period_done));
    sync_host_model sync_host_model_inst (
        .clk(clk), .rst_n(rst_n), .fire(fire), .sync_pulse(sync_pulse));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic test_done();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    // bounded wait, a hang ends the run
    task automatic wait_done();
        int w;
        w = 0;
        do begin
            @(posedge clk);
            #1;
            w++;
        end while (period_done !== 1'b1 && w < 20000);
        if (w >= 20000) begin
            error_cnt++;
            $display("[FAIL] %0t no period end", $time);
            test_done();
        end
    endtask : wait_done

    // sync taken two edges after the request, sampled after that edge
    task automatic send_sync();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
    endtask : send_sync

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        read_addr <= a;
        @(posedge clk);
        #1;
        chk_val({8'h00, read_data}, {8'h00, e}, "read byte");
    endtask : rd

    // modulator pulses at an 80 ns period, kept clear of sync edges
    task automatic burst(input int n);
        #203;
        repeat (n) begin
            quanta_pin = 1'b1;
            #40;
            quanta_pin = 1'b0;
            #40;
        end
    endtask : burst

    task automatic period(input int n);
        fork
            burst(n);
        join_none
        repeat (GAP - 3) @(posedge clk);
        send_sync();
    endtask : period

    initial begin
        int i;
        int k;
        int n;
        int nb;
        int t0;
        int p;
        // internal timing, range changed while running
        for (i = 0; i < 4; i++) begin
            command_reg <= {6'h00, wt[i]};
            do_reset();
            control_reg <= {4'h0, rg[i], 2'h0};
            n = 1 << (16 - 4 * wt[i]);
            p = DIV * (rg[i][1] ? 1 : 2);
            wait_done();
            t0 = cyc_cnt;
            wait_done();
            chk_val(16'(cyc_cnt - t0), 16'(n * p), "period length");
            chk_val(timer_data, n[15:0], "timer count");
            chk_val({15'h0, oscillator_half}, {15'h0, !rg[i][1]}, "half rate");
            rd(8'h06, n[7:0]);
            rd(8'h07, n[15:8]);
        end
        // host timing, diode one fast then diode two slow
        for (i = 0; i < 2; i++) begin
            command_reg <= {4'h2, 1'b0, i[0], 2'h0};
            control_reg <= i ? 8'h00 : 8'h0C;
            p = DIV * (i + 1);
            do_reset();
            send_sync();
            chk_val({15'h0, integrating}, 16'h0001, "start");
            for (k = 0; k < 3; k++) begin
                seed = lfsr(seed);
                n = seed[2:0] + 1;
                period(n);
                chk_val({15'h0, period_done}, 16'h0001, "end pulse");
                chk_val(timer_data, 16'(GAP / p), "cycles");
                chk_val(sensor_data, 16'(n), "counts");
                chk_val({15'h0, diode_two_sel}, {15'h0, i[0]}, "diode");
            end
        end
        // difference mode, second round forces the clamp
        command_reg <= 8'h28;
        control_reg <= 8'h0C;
        do_reset();
        send_sync();
        for (k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            n = seed[2:0];
            nb = k ? n + 1 : seed[5:3];
            period(n);
            chk_val({15'h0, period_done}, 16'h0000, "early end");
            chk_val({15'h0, diode_two_sel}, 16'h0001, "second diode");
            period(nb);
            chk_val(sensor_data, 16'(n > nb ? n - nb : 0), "difference");
            chk_val(timer_data, 16'(GAP / DIV), "second length");
        end
        // idle code refuses sync
        command_reg <= 8'h2C;
        do_reset();
        send_sync();
        chk_val({15'h0, integrating}, 16'h0000, "idle");
        rd(8'h05, 8'h00);
        test_done();
    end
endmodule : light_adc_integration_timing_tb
`default_nettype wire

/* tb/light_timing_monitor.sv */
// port-level assertions for the integration timing block
`timescale 1ns/1ns
`default_nettype none
module light_timing_monitor #(
    parameter int unsigned OSC_DIV = 2
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // watched ports
    input wire logic [7:0]  command_reg,
    input wire logic [7:0]  control_reg,
    input wire logic        sync_pulse,
    input wire logic [7:0]  read_addr,
    input wire logic [7:0]  read_data,
    input wire logic        diode_two_sel,
    input wire logic        integrating,
    input wire logic        oscillator_half,
    input wire logic [15:0] timer_data,
    input wire logic        period_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a sync taken with host timing selected
    sequence s_ext_sync;
        command_reg[5] && sync_pulse;
    endsequence
    sequence s_first;
        s_ext_sync ##0 (!integrating && command_reg[3:2] != 2'h3);
    endsequence
    sequence s_single_end;
        s_ext_sync ##0 (integrating && !command_reg[3]);
    endsequence
    sequence s_diff_mid;
        s_ext_sync ##0 (integrating && command_reg[3:2] == 2'h2 && !diode_two_sel);
    endsequence
    // rate pin is registered straight from control bit 3, one cycle later at any divider
    AST_HALF_RATE: assert property (
        $changed(control_reg[3]) |-> ##[1:8] oscillator_half == !control_reg[3])
        else $error("oscillator rate wrong");
    // back-to-back host syncs may legally give a second pulse
    AST_DONE_PULSE: assert property (
        period_done && !(command_reg[5] && sync_pulse) |=> !period_done)
        else $error("done not one cycle");
    AST_RD_LSB: assert property (
        $past(rst_n) && $past(read_addr) == 8'h06 |-> read_data == $past(timer_data[7:0]))
        else $error("low timer byte wrong");
    AST_RD_MSB: assert property (
        $past(rst_n) && $past(read_addr) == 8'h07 |-> read_data == $past(timer_data[15:8]))
        else $error("high timer byte wrong");
    AST_EXT_START: assert property (
        s_first |=> integrating) else $error("sync did not start");
    AST_EXT_END: assert property (
        s_single_end |=> period_done && integrating) else $error("sync did not restart");
    AST_DIFF_MID: assert property (
        s_diff_mid |=> !period_done && diode_two_sel) else $error("difference step wrong");
    AST_TIMER_HOLD: assert property (
        $past(rst_n) && $changed(timer_data) |-> period_done) else $error("timer moved");
endmodule : light_timing_monitor
bind light_adc_integration_timing light_timing_monitor #(.OSC_DIV(OSC_DIV)) mon_inst (
    .clk(clk), .rst_n(rst_n), .command_reg(command_reg), .control_reg(control_reg),
    .sync_pulse(sync_pulse), .read_addr(read_addr), .read_data(read_data),
    .diode_two_sel(diode_two_sel), .integrating(integrating),
    .oscillator_half(oscillator_half), .timer_data(timer_data), .period_done(period_done));
`default_nettype wire

/* tb/sync_host_model.sv */
// host model that issues one sync command per request
`timescale 1ns/1ns
`default_nettype none
module sync_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // request and sync command
    input  wire logic fire,
    output logic      sync_pulse
);
    logic sync_q;
    logic sync_d;
    // one sync per request, none in reset
    always_comb begin
        sync_d = rst_n & fire;
    end
    // registered so the pulse leaves just after an edge
    always_ff @(posedge clk) begin
        sync_q <= sync_d;
    end
    assign sync_pulse = sync_q;
endmodule : sync_host_model
`default_nettype wire
